/* File: design/srs_defines.svh */
// Constants for the system reset sequencer: register map, field positions, timing.
// Assumes inclusion by bare name from the package and the top module.
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH

// APB byte offsets
`define SRS_OFS_PEND1       12'h000
`define SRS_OFS_PEND2       12'h004
`define SRS_OFS_PEND3       12'h008
`define SRS_OFS_CAUSE       12'h00C
`define SRS_OFS_BRKAUX      12'h010

// Pending flag positions within the three status registers
`define SRS_P1_SRC1_BIT     2
`define SRS_P1_SRC3_BIT     4
`define SRS_P1_SRC4_BIT     5
`define SRS_P1_SRC5_BIT     6
`define SRS_P2_SRC14_BIT    7
`define SRS_P3_SRC15_BIT    0

// Source numbers on the pending input vector
`define SRS_SRC1            1
`define SRS_SRC3            3
`define SRS_SRC4            4
`define SRS_SRC5            5
`define SRS_SRC14           14
`define SRS_SRC15           15

// Break auxiliary register: watchdog disable during break
`define SRS_BRK_WDOG_DIS_BIT 0

// Reset values
`define SRS_CAUSE_RST       5'h10
`define SRS_BRKAUX_RST      1'h0

// Watchdog service address
`define SRS_SERVICE_ADDR    16'hFFFF

// Prescale stages cleared by a service write (stages 12..5 are bits 11..4)
`define SRS_SVC_MSB         11
`define SRS_SVC_LSB         4

// Timing, in fast system clock cycles; clock period in ns
`define SRS_PRESCALE_PERIOD 4080
`define SRS_HOLD_CYCLES     4096
`define SRS_RELEASE_CYCLES  64
`define SRS_STOP_REC_CYCLES 4096
`define SRS_CLK_PERIOD_NS   50

`endif

/* File: design/srs_pkg.sv */
// Types shared by the system reset sequencer.
// Assumes srs_defines.svh is on the include path.
package srs_pkg;
    `include "srs_defines.svh"

    typedef enum logic [2:0] {
        SRS_ST_HOLD,
        SRS_ST_RELEASE,
        SRS_ST_RUN,
        SRS_ST_STOPPED,
        SRS_ST_WAKE
    } srs_state_t;

    // Reset cause flags, wdog in bit 0
    typedef struct packed {
        logic por;
        logic undervoltage;
        logic bad_address;
        logic bad_opcode;
        logic wdog;
    } srs_cause_t;

    // Status signals from the processor core
    typedef struct packed {
        logic        illegal_op;
        logic        stop_exec;
        logic        opfetch;
        logic        unmapped;
        logic        wr;
        logic [15:0] addr;
    } srs_cpu_t;

    // Break state from the debug logic
    typedef struct packed {
        logic brk_active;
        logic monitor_mode;
    } srs_brk_t;
endpackage

/* File: design/srs_top.sv */
// System reset sequencer: gathers reset sources, drives the reset pin, records
// the cause, runs the prescale counter and watchdog, shows interrupt pending state.
// Assumes core status is synchronous to clk_i and an APB master on the same clock.
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "srs_defines.svh"

module srs_top #(
    parameter int WDOG_W          = 8,
    parameter int PRESCALE_PERIOD = `SRS_PRESCALE_PERIOD,
    parameter int HOLD_CYCLES     = `SRS_HOLD_CYCLES,
    parameter int RELEASE_CYCLES  = `SRS_RELEASE_CYCLES,
    parameter int STOP_REC_CYCLES = `SRS_STOP_REC_CYCLES
) (
    input  wire logic             clk_i,
    input  wire logic             srst_i,
    input  wire srs_pkg::srs_cpu_t cpu_i,
    input  wire srs_pkg::srs_brk_t brk_i,
    input  wire logic             stop_permit_i,
    input  wire logic             stop_wake_i,
    input  wire logic             undervoltage_i,
    input  wire logic [15:0]      pending_i,
    input  wire logic             psel_i,
    input  wire logic             penable_i,
    input  wire logic             pwrite_i,
    input  wire logic [11:0]      paddr_i,
    input  wire logic [31:0]      pwdata_i,
    output logic                  pready_o,
    output logic [31:0]           prdata_o,
    output logic                  pslverr_o,
    output logic                  rst_pin_o,
    output logic                  rst_pin_oe_o,
    output logic                  core_rst_o,
    output logic                  bus_clk_en_o
);
    import srs_pkg::*;

    localparam int SEQ_W = 13;

    generate
        if (PRESCALE_PERIOD < 2 || PRESCALE_PERIOD > 4096) begin : g_bad_pre
            $error("PRESCALE_PERIOD must fit the twelve counting stages");
        end
        if (HOLD_CYCLES < 1 || HOLD_CYCLES > 8191 || STOP_REC_CYCLES < 1
            || STOP_REC_CYCLES > 8191 || RELEASE_CYCLES < 1 || RELEASE_CYCLES > 8191)
        begin : g_bad_seq
            $error("Sequence counts must lie in 1..8191");
        end
        if (WDOG_W < 2 || WDOG_W > 31) begin : g_bad_wd
            $error("WDOG_W must lie in 2..31");
        end
    endgenerate

    localparam logic [11:0]      PRE_LAST  = 12'(PRESCALE_PERIOD - 1);
    localparam logic [SEQ_W-1:0] HOLD_LAST = SEQ_W'(HOLD_CYCLES - 1);
    localparam logic [SEQ_W-1:0] REL_LAST  = SEQ_W'(RELEASE_CYCLES - 1);
    localparam logic [SEQ_W-1:0] STOP_LAST = SEQ_W'(STOP_REC_CYCLES - 1);

    srs_state_t         state;
    srs_state_t         next_state;
    logic [SEQ_W-1:0]   seq_cnt;
    logic [SEQ_W-1:0]   next_seq_cnt;
    logic [11:0]        pre_cnt;
    logic               pre_tick;
    logic               svc_write;
    logic [WDOG_W-1:0]  wdog_cnt;
    logic               wdog_ovf;
    logic               brk_wdog_dis;
    srs_cause_t         cause;
    srs_cause_t         events;
    logic               any_event;
    logic               apb_access;
    logic               apb_wr;
    logic               apb_rd;
    logic [7:0]         pend1;
    logic [7:0]         pend2;
    logic [7:0]         pend3;

    // Service write to the top address, registered for the prescale domain
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            svc_write <= 1'b0;
        end else begin
            svc_write <= cpu_i.wr && (cpu_i.addr == `SRS_SERVICE_ADDR);
        end
    end

    // Prescale counter on the falling edge, 13th stage as one-cycle tick
    always_ff @(negedge clk_i) begin
        if (srst_i) begin
            pre_cnt  <= 12'h000;
            pre_tick <= 1'b0;
        end else if (svc_write) begin
            pre_cnt[`SRS_SVC_MSB:`SRS_SVC_LSB] <= '0;
            pre_tick <= 1'b0;
        end else if (pre_cnt == PRE_LAST) begin
            pre_cnt  <= 12'h000;
            pre_tick <= 1'b1;
        end else begin
            pre_cnt  <= pre_cnt + 12'h001;
            pre_tick <= 1'b0;
        end
    end

    // Watchdog counter, clocked by clk_i and stepped by the prescale tick
    assign wdog_ovf = (state == SRS_ST_RUN) && pre_tick && (&wdog_cnt)
                      && !(brk_i.brk_active && brk_i.monitor_mode && brk_wdog_dis);

    always_ff @(posedge clk_i) begin
        if (srst_i || state != SRS_ST_RUN || svc_write) begin
            wdog_cnt <= '0;
        end else if (pre_tick
                     && !(brk_i.brk_active && brk_i.monitor_mode && brk_wdog_dis)) begin
            wdog_cnt <= wdog_cnt + WDOG_W'(1);
        end
    end

    // Reset sources
    always_comb begin
        events              = '0;
        events.wdog         = wdog_ovf;
        events.bad_opcode   = (state == SRS_ST_RUN)
                              && (cpu_i.illegal_op
                                  || (cpu_i.stop_exec && !stop_permit_i));
        // Only opcode fetches count; data reads of unmapped space are ignored
        events.bad_address  = (state == SRS_ST_RUN)
                              && cpu_i.opfetch && cpu_i.unmapped;
        events.undervoltage = undervoltage_i;
    end

    assign any_event = |events;

    // Sequencer
    always_comb begin
        next_state   = state;
        next_seq_cnt = seq_cnt + SEQ_W'(1);
        case (state)
            SRS_ST_HOLD: begin
                if (undervoltage_i) begin
                    next_seq_cnt = '0;
                end else if (seq_cnt == HOLD_LAST) begin
                    next_state   = SRS_ST_RELEASE;
                    next_seq_cnt = '0;
                end
            end
            SRS_ST_RELEASE: begin
                if (undervoltage_i) begin
                    next_state   = SRS_ST_HOLD;
                    next_seq_cnt = '0;
                end else if (seq_cnt == REL_LAST) begin
                    next_state   = SRS_ST_RUN;
                    next_seq_cnt = '0;
                end
            end
            SRS_ST_RUN: begin
                next_seq_cnt = '0;
                if (any_event) begin
                    next_state = SRS_ST_HOLD;
                end else if (cpu_i.stop_exec && stop_permit_i) begin
                    next_state = SRS_ST_STOPPED;
                end
            end
            SRS_ST_STOPPED: begin
                next_seq_cnt = '0;
                if (undervoltage_i) begin
                    next_state = SRS_ST_HOLD;
                end else if (stop_wake_i) begin
                    next_state = SRS_ST_WAKE;
                end
            end
            SRS_ST_WAKE: begin
                if (undervoltage_i) begin
                    next_state   = SRS_ST_HOLD;
                    next_seq_cnt = '0;
                end else if (seq_cnt == STOP_LAST) begin
                    next_state   = SRS_ST_RUN;
                    next_seq_cnt = '0;
                end
            end
            default: begin
                next_state   = SRS_ST_HOLD;
                next_seq_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state   <= SRS_ST_HOLD;
            seq_cnt <= '0;
        end else begin
            state   <= next_state;
            seq_cnt <= next_seq_cnt;
        end
    end

    // Pin, core reset and bus clock enable, all registered
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_o <= 1'b1;
            core_rst_o   <= 1'b1;
            bus_clk_en_o <= 1'b0;
        end else begin
            rst_pin_o    <= 1'b0;
            rst_pin_oe_o <= (next_state == SRS_ST_HOLD);
            core_rst_o   <= (next_state == SRS_ST_HOLD)
                            || (next_state == SRS_ST_RELEASE);
            bus_clk_en_o <= (next_state == SRS_ST_RELEASE)
                            || (next_state == SRS_ST_RUN);
        end
    end

    // APB slave: one wait state, answer registered
    assign apb_access = psel_i && penable_i && pready_o;
    assign apb_wr     = apb_access && pwrite_i;
    assign apb_rd     = psel_i && penable_i && !pready_o && !pwrite_i;

    // Cause register: write one to clear, new events win over the clear
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cause <= srs_cause_t'(`SRS_CAUSE_RST);
        end else if (apb_wr && paddr_i == `SRS_OFS_CAUSE) begin
            cause <= (cause & ~srs_cause_t'(pwdata_i[4:0])) | events;
        end else begin
            cause <= cause | events;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            brk_wdog_dis <= `SRS_BRKAUX_RST;
        end else if (apb_wr && paddr_i == `SRS_OFS_BRKAUX) begin
            brk_wdog_dis <= pwdata_i[`SRS_BRK_WDOG_DIS_BIT];
        end
    end

    // Live pending views; writes to these offsets are ignored
    always_comb begin
        pend1                    = 8'h00;
        pend1[`SRS_P1_SRC1_BIT]  = pending_i[`SRS_SRC1];
        pend1[`SRS_P1_SRC3_BIT]  = pending_i[`SRS_SRC3];
        pend1[`SRS_P1_SRC4_BIT]  = pending_i[`SRS_SRC4];
        pend1[`SRS_P1_SRC5_BIT]  = pending_i[`SRS_SRC5];
        pend2                    = 8'h00;
        pend2[`SRS_P2_SRC14_BIT] = pending_i[`SRS_SRC14];
        pend3                    = 8'h00;
        pend3[`SRS_P3_SRC15_BIT] = pending_i[`SRS_SRC15];
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= psel_i && penable_i && !pready_o;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            if (psel_i && penable_i && !pready_o) begin
                case (paddr_i)
                    `SRS_OFS_PEND1:  prdata_o[7:0] <= apb_rd ? pend1 : 8'h00;
                    `SRS_OFS_PEND2:  prdata_o[7:0] <= apb_rd ? pend2 : 8'h00;
                    `SRS_OFS_PEND3:  prdata_o[7:0] <= apb_rd ? pend3 : 8'h00;
                    `SRS_OFS_CAUSE:  prdata_o[4:0] <= apb_rd ? cause : 5'h00;
                    `SRS_OFS_BRKAUX: prdata_o[0]   <= apb_rd ? brk_wdog_dis : 1'b0;
                    default:         pslverr_o     <= 1'b1;
                endcase
            end
        end
    end
endmodule

/* File: dv/srs_top_props.sv */
// Checker for the reset sequencer: event response, pin hold, release and APB reads.
// Assumes one clock domain; bound into every srs_top instance below.
`timescale 1ns/100ps

module srs_top_props
    import srs_pkg::*;
#(
    parameter int HOLD_CYCLES    = 4096,
    parameter int RELEASE_CYCLES = 64
) (
    input wire logic              clk_i,
    input wire logic              srst_i,
    input wire srs_pkg::srs_cpu_t cpu_i,
    input wire logic              stop_permit_i,
    input wire logic              undervoltage_i,
    input wire logic              psel_i,
    input wire logic              penable_i,
    input wire logic              pwrite_i,
    input wire logic [11:0]       paddr_i,
    input wire logic              pready_o,
    input wire logic [31:0]       prdata_o,
    input wire logic              pslverr_o,
    input wire logic              rst_pin_o,
    input wire logic              rst_pin_oe_o,
    input wire logic              core_rst_o,
    input wire logic              bus_clk_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);

    logic        run_now;
    logic [15:0] hold_cnt;
    logic [15:0] rel_cnt;
    logic [31:0] zero_mask;

    assign run_now = !core_rst_o && bus_clk_en_o;

    // Pin hold length since undervoltage last dropped
    always_ff @(posedge clk_i) begin
        hold_cnt <= (srst_i || undervoltage_i || !rst_pin_oe_o) ? 16'h0000 : hold_cnt + 16'h0001;
    end

    always_ff @(posedge clk_i) begin
        rel_cnt <= (core_rst_o && !rst_pin_oe_o) ? rel_cnt + 16'h0001 : 16'h0000;
    end

    always_comb begin
        case (paddr_i)
            12'h000: zero_mask = 32'hFFFF_FF8B;
            12'h004: zero_mask = 32'hFFFF_FF7F;
            12'h008: zero_mask = 32'hFFFF_FFFE;
            default: zero_mask = 32'h0000_0000;
        endcase
    end

    sequence s_reset_on;
        rst_pin_oe_o && core_rst_o && !bus_clk_en_o;
    endsequence

    sequence s_ready_pulse;
        pready_o ##1 !pready_o;
    endsequence

    pin_low_a: assert property (rst_pin_oe_o |-> !rst_pin_o)
        else $error("reset pin driven high");
    core_held_a: assert property (rst_pin_oe_o |-> core_rst_o)
        else $error("core left reset during pin hold");
    clk_gate_a: assert property (rst_pin_oe_o |-> !bus_clk_en_o)
        else $error("bus clocks on during pin hold");
    bad_opcode_a: assert property (run_now && cpu_i.illegal_op |=> s_reset_on)
        else $error("illegal opcode gave no reset");
    stop_trap_a: assert property (run_now && cpu_i.stop_exec && !stop_permit_i
        |=> s_reset_on)
        else $error("forbidden stop gave no reset");
    bad_fetch_a: assert property (run_now && cpu_i.opfetch && cpu_i.unmapped
        |=> s_reset_on)
        else $error("unmapped fetch gave no reset");
    undervolt_a: assert property (undervoltage_i |=> s_reset_on)
        else $error("undervoltage gave no reset");
    hold_len_a: assert property ($fell(rst_pin_oe_o) |->
        hold_cnt >= HOLD_CYCLES - 2 && hold_cnt <= HOLD_CYCLES + 1)
        else $error("pin hold length wrong");
    release_len_a: assert property ($fell(core_rst_o) |->
        rel_cnt >= RELEASE_CYCLES - 1 && rel_cnt <= RELEASE_CYCLES + 1)
        else $error("release delay wrong");
    apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> s_ready_pulse)
        else $error("APB answer not one wait state");
    unmapped_err_a: assert property (pready_o && paddr_i > 12'h010 |-> pslverr_o)
        else $error("unmapped access without error");
    status_zero_a: assert property (pready_o && !pwrite_i
        |-> !(|(prdata_o & zero_mask)))
        else $error("status reserved bit set");
endmodule

bind srs_top srs_top_props #(
    .HOLD_CYCLES(HOLD_CYCLES),
    .RELEASE_CYCLES(RELEASE_CYCLES)
) props_u (
    .clk_i(clk_i), .srst_i(srst_i), .cpu_i(cpu_i), .stop_permit_i(stop_permit_i),
    .undervoltage_i(undervoltage_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
    .core_rst_o(core_rst_o), .bus_clk_en_o(bus_clk_en_o)
);

/* File: dv/srs_core_model.sv */
// Core side model: one-cycle event pulses on command and periodic watchdog service.
// Assumes go_i is raised for one cycle just after a rising edge.
`timescale 1ns/100ps

module srs_core_model
    import srs_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         go_i,
    input  wire logic [2:0]   kind_i,
    input  wire logic         svc_en_i,
    output srs_pkg::srs_cpu_t cpu_o
);
    logic [3:0] gap = 4'h0;

    initial cpu_o = '0;

    // Fields: illegal_op, stop_exec, opfetch, unmapped, wr, then addr
    always @(posedge clk_i) begin
        gap <= gap + 4'h1;
        if (go_i) begin
            case (kind_i)
                3'h0:    cpu_o <= 21'h10_7F00;
                3'h1:    cpu_o <= 21'h08_7F00;
                3'h2:    cpu_o <= 21'h06_7F00;
                3'h3:    cpu_o <= 21'h02_7F00;
                default: cpu_o <= 21'h16_7F00;
            endcase
        end else if (svc_en_i && gap == 4'h0) begin
            cpu_o <= 21'h01_FFFF;
        end else begin
            // Idle address keeps changing so no stale value is seen
            cpu_o <= {5'h00, ~cpu_o.addr};
        end
    end
endmodule

/* File: dv/test_system_reset_and_counter_logic.sv */
// Testbench for the reset sequencer: reset causes, pin hold, watchdog, stop, status.
// Assumes srs_pkg, srs_top, the core model and the bound checker are compiled first.
`timescale 1ns/100ps
`include "srs_defines.svh"

module test_system_reset_and_counter_logic;
    import srs_pkg::*;

    logic        clk_i = 1'b0;
    logic        srst_i = 1'b1;
    srs_cpu_t    cpu;
    srs_brk_t    brk = '0;
    logic        stop_permit = 1'b0;
    logic        stop_wake = 1'b0;
    logic        uv = 1'b0;
    logic [15:0] pending = 16'h0000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        pready, pslverr, rst_pin, rst_pin_oe, core_rst, bus_clk_en;
    logic [31:0] prdata;
    logic        go = 1'b0;
    logic [2:0]  kind = 3'h0;
    logic        svc_en = 1'b1;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    always #25 clk_i = ~clk_i;

    srs_top #(.WDOG_W(3), .PRESCALE_PERIOD(8), .HOLD_CYCLES(16), .RELEASE_CYCLES(4),
              .STOP_REC_CYCLES(16)) dut_u (
        .clk_i(clk_i), .srst_i(srst_i), .cpu_i(cpu), .brk_i(brk), .stop_permit_i(stop_permit),
        .stop_wake_i(stop_wake), .undervoltage_i(uv), .pending_i(pending), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .rst_pin_o(rst_pin),
        .rst_pin_oe_o(rst_pin_oe), .core_rst_o(core_rst), .bus_clk_en_o(bus_clk_en));
    srs_core_model core_u (.clk_i(clk_i), .go_i(go), .kind_i(kind), .svc_en_i(svc_en),
                           .cpu_o(cpu));

    task automatic summarize();
        if (num_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_for(ref logic s, input logic v, input int lim);
        for (int n = 0; n < lim && s !== v; n++) begin
            @(posedge clk_i);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n = 0;
        @(posedge clk_i);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        // Wait states counted until pready is seen high at a rising edge
        while (pready !== 1'b1) begin
            n++;
            @(posedge clk_i);
        end
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        chk("apb wait states", n, 32'h1);
    endtask

    task automatic pulse(input logic [2:0] k);
        @(posedge clk_i);
        go   <= 1'b1;
        kind <= k;
        @(posedge clk_i);
        go   <= 1'b0;
    endtask

    task automatic expect_reset(input string what, input logic [4:0] cause, input int lim);
        logic [31:0] q;
        logic        e;
        wait_for(rst_pin_oe, 1'b1, lim);
        chk({what, " pin"}, {31'h0, rst_pin_oe}, 32'h1);
        chk({what, " pin level"}, {31'h0, rst_pin}, 32'h0);
        chk({what, " bus clock"}, {31'h0, bus_clk_en}, 32'h0);
        wait_for(core_rst, 1'b0, 200);
        chk({what, " release"}, {31'h0, core_rst}, 32'h0);
        apb(1'b0, `SRS_OFS_CAUSE, 32'h0, q, e);
        chk({what, " cause"}, q, {27'h0, cause});
        apb(1'b1, `SRS_OFS_CAUSE, 32'h0000_001F, q, e);
    endtask

    initial begin
        logic [31:0] q;
        logic        e;
        logic [15:0] pat [5] = '{16'h0002, 16'h0038, 16'h4000, 16'h8000, 16'hFFFF};
        logic [23:0] expv [5] = '{24'h04_0000, 24'h70_0000, 24'h00_8000, 24'h00_0001,
                                  24'h74_8001};
        logic [2:0]  kinds [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
        logic [4:0]  causes [4] = '{5'h02, 5'h02, 5'h04, 5'h06};
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        expect_reset("power-on", 5'h10, 4);
        apb(1'b0, `SRS_OFS_BRKAUX, 32'h0, q, e);
        chk("break aux reset", q, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            pending <= pat[i];
            for (int r = 0; r < 3; r++) begin
                apb(1'b1, 12'(4 * r), 32'hFFFF_FFFF, q, e);
                apb(1'b0, 12'(4 * r), 32'h0, q, e);
                chk("status", q, {24'h0, expv[i][23-8*r -: 8]});
            end
        end
        apb(1'b0, 12'h020, 32'h0, q, e);
        chk("unmapped error", {31'h0, e}, 32'h1);
        for (int i = 0; i < 4; i++) begin
            pulse(kinds[i]);
            expect_reset("core event", causes[i], 10);
        end
        pulse(3'h3);
        repeat (20) @(posedge clk_i);
        chk("data read unmapped", {31'h0, rst_pin_oe}, 32'h0);
        apb(1'b0, `SRS_OFS_CAUSE, 32'h0, q, e);
        chk("cause after data read", q, 32'h0);
        uv <= 1'b1;
        repeat (5) @(posedge clk_i);
        uv <= 1'b0;
        expect_reset("undervoltage", 5'h08, 10);
        repeat (300) @(posedge clk_i);
        chk("serviced watchdog", {31'h0, rst_pin_oe}, 32'h0);
        apb(1'b0, `SRS_OFS_CAUSE, 32'h0, q, e);
        chk("cause when serviced", q, 32'h0);
        apb(1'b1, `SRS_OFS_BRKAUX, 32'h0000_0001, q, e);
        brk    <= '{brk_active: 1'b1, monitor_mode: 1'b1};
        svc_en <= 1'b0;
        repeat (300) @(posedge clk_i);
        chk("watchdog in break", {31'h0, rst_pin_oe}, 32'h0);
        apb(1'b0, `SRS_OFS_CAUSE, 32'h0, q, e);
        chk("cause in break", q, 32'h0);
        brk <= '0;
        expect_reset("watchdog", 5'h01, 80);
        svc_en      <= 1'b1;
        stop_permit <= 1'b1;
        pulse(3'h1);
        wait_for(bus_clk_en, 1'b0, 10);
        chk("stop clock gate", {31'h0, bus_clk_en}, 32'h0);
        chk("permitted stop", {31'h0, rst_pin_oe}, 32'h0);
        stop_wake <= 1'b1;
        @(posedge clk_i);
        stop_wake <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk("stop wake delay", {31'h0, bus_clk_en}, 32'h0);
        wait_for(bus_clk_en, 1'b1, 60);
        chk("stop recovery", {31'h0, bus_clk_en}, 32'h1);
        apb(1'b0, `SRS_OFS_CAUSE, 32'h0, q, e);
        chk("cause after stop", q, 32'h0);
        summarize();
    end
endmodule
